// File: core/psfra_consts.vh
// constants for the packed simd / floating-point register alias file
`ifndef PSFRA_CONSTS_VH
`define PSFRA_CONSTS_VH
`define PSFRA_NREG 8
`define PSFRA_IDX_W 3
`define PSFRA_REG_W 80
`define PSFRA_PK_W 64
`define PSFRA_EXP_LSB 64
`define PSFRA_EXP_MSB 79
`define PSFRA_TOS_LSB 11
`define PSFRA_TOS_MSB 13
`define PSFRA_TAG_VALID 2'h0
`define PSFRA_TAG_ZERO 2'h1
`define PSFRA_TAG_SPECIAL 2'h2
`define PSFRA_TAG_EMPTY 2'h3
`define PSFRA_TOS_ZERO 3'h0
`define PSFRA_EXP_ONES 16'hffff
`define PSFRA_EXP_ALL1 15'h7fff
`define PSFRA_EXP_ZERO 15'h0000
`define PSFRA_BEXP_MSB 78
`define PSFRA_JBIT 63
`define PSFRA_SW_RST 16'h0000
`define PSFRA_TW_RST 16'hffff
// operation codes from the pipeline
`define PSFRA_OP_NONE 4'h0
`define PSFRA_OP_PK_RD 4'h1
`define PSFRA_OP_PK_WR 4'h2
`define PSFRA_OP_PK_CLR 4'h3
`define PSFRA_OP_FP_WR 4'h4
`define PSFRA_OP_FP_FREE 4'h5
`define PSFRA_OP_FP_RD 4'h6
`define PSFRA_OP_SAVE 4'h7
`define PSFRA_OP_RESTORE 4'h8
`endif

// File: core/psfra_regfile.v
// aliased packed-integer / floating-point register file with tag and stack-top handling
//
// Summary of operation
// RULE_01 - emulation flag set: packed instruction gives invalid-opcode fault, never executes
// RULE_02 - emulation clear: executes if task-switched 0, else device-absent fault
// RULE_03 - eight 64-bit packed registers are low bits of fp registers 0..7
// RULE_04 - packed register n always maps to physical register n, ignoring stack top
// RULE_05 - packed writes show in fp low 64 bits, and fp writes in packed reads
// RULE_06 - packed write sets bits 64..79 to ones; packed read leaves them
// RULE_07 - packed instructions other than state clear set all tags valid
// RULE_08 - state clear sets all tags empty, leaving register data unchanged
// RULE_09 - every packed instruction forces stack-top field to zero
// RULE_10 - packed instructions keep other status bits and fp control state
// RULE_11 - tags never influence packed register contents or packed execution
// RULE_12 - save group reports each register class as tag: empty/nonzero/zero/special
// RULE_13 - after a save group instruction all live tags become empty
// RULE_14 - restore: stored empty stays empty, others classified from restored value; code writes no register data and classifies current contents
// RULE_15 - ordinary fp instructions update only the modified register tag
// RULE_16 - one 80-bit array holds both views, no coherence logic
`timescale 1ns/1ps
`include "psfra_consts.vh"

module psfra_regfile #(
  parameter NREG = `PSFRA_NREG
) (
  // clock and reset
  input wire i_ref_clk,
  input wire i_srst,
  // machine control flags
  input wire i_emulation_flag,
  input wire i_task_switched_flag,
  // operation request
  input wire i_op_valid,
  input wire [3:0] i_op_code,
  input wire [`PSFRA_IDX_W-1:0] i_op_idx,
  input wire [`PSFRA_REG_W-1:0] i_op_data,
  input wire [15:0] i_op_mem_tags,
  input wire [15:0] i_op_status,
  // results
  output reg o_done,
  output reg o_invalid_opcode_fault,
  output reg o_device_absent_fault,
  output reg [`PSFRA_PK_W-1:0] o_packed_data,
  output reg [`PSFRA_REG_W-1:0] o_fp_data,
  output reg [15:0] o_saved_tags,
  output reg [15:0] o_tag_word,
  output reg [15:0] o_status_word
);

  // ***************************************
  // operation decode
  // ***************************************
  wire is_pk_rd;
  wire is_pk_wr;
  wire is_pk_clr;
  wire is_fp_wr;
  wire is_fp_free;
  wire is_fp_rd;
  wire is_save;
  wire is_restore;
  wire is_pk;

  assign is_pk_rd = (i_op_code == `PSFRA_OP_PK_RD);
  assign is_pk_wr = (i_op_code == `PSFRA_OP_PK_WR);
  assign is_pk_clr = (i_op_code == `PSFRA_OP_PK_CLR);
  assign is_fp_wr = (i_op_code == `PSFRA_OP_FP_WR);
  assign is_fp_free = (i_op_code == `PSFRA_OP_FP_FREE);
  assign is_fp_rd = (i_op_code == `PSFRA_OP_FP_RD);
  assign is_save = (i_op_code == `PSFRA_OP_SAVE);
  assign is_restore = (i_op_code == `PSFRA_OP_RESTORE);
  assign is_pk = is_pk_rd || is_pk_wr || is_pk_clr;

  // ***************************************
  // request gating
  // ***************************************
  wire refuse_ud;
  wire refuse_nm;
  wire run;

  // RULE_01 emulation fault wins
  assign refuse_ud = i_op_valid && is_pk && i_emulation_flag;
  // RULE_02 task-switched fault
  assign refuse_nm = i_op_valid && is_pk && !i_emulation_flag && i_task_switched_flag;
  // a refused request changes no state at all
  assign run = i_op_valid && !refuse_ud && !refuse_nm;

  // ***************************************
  // storage
  // ***************************************
  // RULE_16 single array
  reg [`PSFRA_REG_W-1:0] regs_r [0:NREG-1];
  reg [15:0] tag_r;
  reg [15:0] sw_r;
  integer r;

  // ***************************************
  // next values
  // ***************************************
  reg [15:0] tag_nxt;
  reg [15:0] sw_nxt;
  reg wr_en_nxt;
  reg [`PSFRA_REG_W-1:0] wr_data_nxt;
  reg [15:0] save_cls;
  reg [15:0] rst_cls;
  integer k;

  // ***************************************
  // whole-word tag patterns
  // ***************************************
  wire [15:0] all_valid;
  wire [15:0] all_empty;
  assign all_valid = {NREG{`PSFRA_TAG_VALID}};
  assign all_empty = {NREG{`PSFRA_TAG_EMPTY}};

  // ***************************************
  // classification of every register
  // ***************************************
  wire [15:0] reg_cls;
  genvar g;
  generate
    for (g = 0; g < NREG; g = g + 1) begin : g_cls
      psfra_class_unit i_psfra_class_unit (
        .i_value(regs_r[g]),
        .o_class(reg_cls[2*g +: 2])
      );
    end
  endgenerate

  always @* begin
    save_cls = 16'h0000;
    rst_cls = 16'h0000;
    for (k = 0; k < NREG; k = k + 1) begin
      // RULE_12 empty stays empty
      if (tag_r[2*k +: 2] == `PSFRA_TAG_EMPTY) begin
        save_cls[2*k +: 2] = `PSFRA_TAG_EMPTY;
      end else begin
        save_cls[2*k +: 2] = reg_cls[2*k +: 2];
      end
      // RULE_14 stored empty wins
      if (i_op_mem_tags[2*k +: 2] == `PSFRA_TAG_EMPTY) begin
        rst_cls[2*k +: 2] = `PSFRA_TAG_EMPTY;
      end else begin
        rst_cls[2*k +: 2] = reg_cls[2*k +: 2];
      end
    end
  end

  // ***************************************
  // next state
  // ***************************************
  always @* begin
    tag_nxt = tag_r;
    sw_nxt = sw_r;
    wr_en_nxt = 1'b0;
    wr_data_nxt = i_op_data;
    if (run) begin
      // RULE_09 RULE_10 stack top only
      if (is_pk) begin
        sw_nxt[`PSFRA_TOS_MSB:`PSFRA_TOS_LSB] = `PSFRA_TOS_ZERO;
      end
      // RULE_11 tags never steer packed ops
      case (i_op_code)
        `PSFRA_OP_PK_RD: begin
          // RULE_07 tags valid
          tag_nxt = all_valid;
        end
        `PSFRA_OP_PK_WR: begin
          // RULE_05 RULE_06 ones above data
          wr_en_nxt = 1'b1;
          wr_data_nxt = {`PSFRA_EXP_ONES, i_op_data[`PSFRA_PK_W-1:0]};
          // RULE_07 tags valid
          tag_nxt = all_valid;
        end
        `PSFRA_OP_PK_CLR: begin
          // RULE_08 tags empty, data kept
          tag_nxt = all_empty;
        end
        `PSFRA_OP_FP_WR: begin
          // RULE_05 RULE_15 full write, own tag
          wr_en_nxt = 1'b1;
          wr_data_nxt = i_op_data;
          tag_nxt[2*i_op_idx +: 2] = `PSFRA_TAG_VALID;
          sw_nxt = i_op_status;
        end
        `PSFRA_OP_FP_FREE: begin
          // RULE_15 own tag empty
          tag_nxt[2*i_op_idx +: 2] = `PSFRA_TAG_EMPTY;
          sw_nxt = i_op_status;
        end
        `PSFRA_OP_FP_RD: begin
          // plain reads leave the tags alone
          tag_nxt = tag_r;
        end
        `PSFRA_OP_SAVE: begin
          // RULE_13 tags empty after save
          tag_nxt = all_empty;
        end
        `PSFRA_OP_RESTORE: begin
          // RULE_14 derived tags
          tag_nxt = rst_cls;
          sw_nxt = i_op_status;
        end
        default: begin
          tag_nxt = tag_r;
        end
      endcase
    end
  end

  // ***************************************
  // register update
  // ***************************************
  always @(posedge i_ref_clk) begin
    if (i_srst) begin
      for (r = 0; r < NREG; r = r + 1) begin
        regs_r[r] <= {`PSFRA_REG_W{1'b0}};
      end
      tag_r <= `PSFRA_TW_RST;
      sw_r <= `PSFRA_SW_RST;
    end else begin
      // RULE_03 RULE_04 physical index only
      if (wr_en_nxt) begin
        regs_r[i_op_idx] <= wr_data_nxt;
      end
      tag_r <= tag_nxt;
      sw_r <= sw_nxt;
    end
  end

  // ***************************************
  // outputs
  // ***************************************
  always @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_done <= 1'b0;
      o_invalid_opcode_fault <= 1'b0;
      o_device_absent_fault <= 1'b0;
      o_packed_data <= {`PSFRA_PK_W{1'b0}};
      o_fp_data <= {`PSFRA_REG_W{1'b0}};
      o_saved_tags <= 16'h0000;
      o_tag_word <= `PSFRA_TW_RST;
      o_status_word <= `PSFRA_SW_RST;
    end else begin
      // pulses last one cycle
      o_done <= run;
      o_invalid_opcode_fault <= refuse_ud;
      o_device_absent_fault <= refuse_nm;
      // tag and status words lag the state by one clock
      o_tag_word <= tag_r;
      o_status_word <= sw_r;
      // RULE_04 fixed index read
      if (run && is_pk_rd) begin
        o_packed_data <= regs_r[i_op_idx][`PSFRA_PK_W-1:0];
      end
      if (run && is_fp_rd) begin
        o_fp_data <= regs_r[i_op_idx];
      end
      // RULE_12 classes reported
      if (run && is_save) begin
        o_saved_tags <= save_cls;
      end
    end
  end

endmodule // psfra_regfile

// ***************************************
// class of one register value
// ***************************************
module psfra_class_unit (
  // register value
  input wire [`PSFRA_REG_W-1:0] i_value,
  // tag class
  output reg [1:0] o_class
);

  wire [14:0] bexp;
  wire jbit;
  wire [`PSFRA_PK_W-1:0] mant;
  wire exp_ones;
  wire exp_zero;

  // the sign bit never changes the class
  assign bexp = i_value[`PSFRA_BEXP_MSB:`PSFRA_EXP_LSB];
  assign jbit = i_value[`PSFRA_JBIT];
  assign mant = i_value[`PSFRA_PK_W-1:0];
  assign exp_ones = (bexp == `PSFRA_EXP_ALL1);
  assign exp_zero = (bexp == `PSFRA_EXP_ZERO);

  // RULE_12 RULE_14 class of one value
  always @* begin
    if (exp_ones) begin
      o_class = `PSFRA_TAG_SPECIAL;
    end else if (!exp_zero && !jbit) begin
      // unnormal
      o_class = `PSFRA_TAG_SPECIAL;
    end else if (exp_zero && mant != {`PSFRA_PK_W{1'b0}}) begin
      // denormal
      o_class = `PSFRA_TAG_SPECIAL;
    end else if (exp_zero) begin
      o_class = `PSFRA_TAG_ZERO;
    end else begin
      o_class = `PSFRA_TAG_VALID;
    end
  end

endmodule // psfra_class_unit

// File: bench/psfra_pipe_model.sv
// pipeline model that issues one-cycle operation strobes
`timescale 1ns/1ps
module psfra_pipe_model (
  // clock
  input wire i_ref_clk,
  // operation request
  output reg o_op_valid = 1'b0,
  output reg [3:0] o_op_code = 4'h0,
  output reg [2:0] o_op_idx = 3'h0,
  output reg [79:0] o_op_data = 80'h0,
  output reg [15:0] o_op_mem_tags = 16'h0,
  output reg [15:0] o_op_status = 16'h0
);
  task issue(input [3:0] c, input [2:0] n, input [79:0] d, input [15:0] t, input [15:0] s);
    begin
      @(posedge i_ref_clk);
      o_op_valid <= 1'b1;
      o_op_code <= c;
      o_op_idx <= n;
      o_op_data <= d;
      o_op_mem_tags <= t;
      o_op_status <= s;
      @(posedge i_ref_clk);
      o_op_valid <= 1'b0;
      // released data never keeps its last value
      o_op_data <= ~d;
    end
  endtask
endmodule // psfra_pipe_model

// File: bench/psfra_properties.sv
// assertions on the aliased register file ports
`timescale 1ns/1ps
module psfra_properties (
  input wire i_ref_clk,
  input wire i_srst,
  input wire i_emulation_flag,
  input wire i_task_switched_flag,
  input wire i_op_valid,
  input wire [3:0] i_op_code,
  input wire o_done,
  input wire o_invalid_opcode_fault,
  input wire o_device_absent_fault,
  input wire [15:0] o_tag_word,
  input wire [15:0] o_status_word
);
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_srst);
  sequence s_pk;
    i_op_valid && i_op_code inside {[4'h1:4'h3]};
  endsequence
  sequence s_ok;
    s_pk ##0 !i_emulation_flag && !i_task_switched_flag;
  endsequence
  AST_UD: assert property (s_pk ##0 i_emulation_flag |=> o_invalid_opcode_fault && !o_done)
    else $error("invalid opcode fault missing");
  AST_NM: assert property (s_pk ##0 !i_emulation_flag && i_task_switched_flag |=>
    o_device_absent_fault && !o_invalid_opcode_fault) else $error("device absent fault missing");
  AST_VALID: assert property (s_ok ##0 i_op_code == 4'h2 |=> ##1 o_tag_word == 16'h0)
    else $error("tags not valid after packed write");
  AST_CLR: assert property (s_ok ##0 i_op_code == 4'h3 |=> ##1 o_tag_word == 16'hffff)
    else $error("tags not empty after state clear");
  AST_TOS: assert property (s_ok |=> ##1 o_status_word[13:11] == 3'h0)
    else $error("stack top not zero");
  AST_KEEP: assert property (s_ok |=> ##1 {o_status_word[15:14], o_status_word[10:0]} ==
    $past({o_status_word[15:14], o_status_word[10:0]})) else $error("status bits changed");
  AST_REF: assert property (s_pk ##0 (i_emulation_flag || i_task_switched_flag) |=>
    ##1 $stable(o_tag_word) && $stable(o_status_word)) else $error("refused op changed state");
  AST_SAVE: assert property (i_op_valid && i_op_code == 4'h7 |=> o_done ##1 o_tag_word == 16'hffff)
    else $error("tags not empty after save");
  AST_RUN: assert property (s_ok |=> o_done && !o_invalid_opcode_fault && !o_device_absent_fault)
    else $error("allowed packed op not executed");
endmodule // psfra_properties
bind psfra_regfile psfra_properties i_psfra_properties (.i_ref_clk(i_ref_clk), .i_srst(i_srst),
  .i_emulation_flag(i_emulation_flag), .i_task_switched_flag(i_task_switched_flag),
  .i_op_valid(i_op_valid), .i_op_code(i_op_code), .o_done(o_done),
  .o_invalid_opcode_fault(o_invalid_opcode_fault), .o_device_absent_fault(o_device_absent_fault),
  .o_tag_word(o_tag_word), .o_status_word(o_status_word));

// File: bench/psfra_regfile_bench.sv
// self-checking bench for the aliased register file
`timescale 1ns/1ps
module psfra_regfile_bench;
  reg i_ref_clk = 1'b0;
  reg i_srst = 1'b1;
  reg i_emulation_flag = 1'b0;
  reg i_task_switched_flag = 1'b0;
  reg [15:0] lf = 16'hc41a;
  reg [79:0] d;
  reg [15:0] s = 16'h0;
  reg ud;
  reg nm;
  reg dn;
  integer n_fail = 0;
  integer total_checks = 0;
  integer k;
  wire i_op_valid;
  wire [3:0] i_op_code;
  wire [2:0] i_op_idx;
  wire [79:0] i_op_data;
  wire [15:0] i_op_mem_tags;
  wire [15:0] i_op_status;
  wire o_done;
  wire o_invalid_opcode_fault;
  wire o_device_absent_fault;
  wire [63:0] o_packed_data;
  wire [79:0] o_fp_data;
  wire [15:0] o_saved_tags;
  wire [15:0] o_tag_word;
  wire [15:0] o_status_word;
  always #2 i_ref_clk = ~i_ref_clk;
  psfra_pipe_model i_psfra_pipe_model (.i_ref_clk(i_ref_clk), .o_op_valid(i_op_valid),
    .o_op_code(i_op_code), .o_op_idx(i_op_idx), .o_op_data(i_op_data),
    .o_op_mem_tags(i_op_mem_tags), .o_op_status(i_op_status));
  psfra_regfile i_psfra_regfile (.i_ref_clk(i_ref_clk), .i_srst(i_srst),
    .i_emulation_flag(i_emulation_flag), .i_task_switched_flag(i_task_switched_flag),
    .i_op_valid(i_op_valid), .i_op_code(i_op_code), .i_op_idx(i_op_idx),
    .i_op_data(i_op_data), .i_op_mem_tags(i_op_mem_tags), .i_op_status(i_op_status),
    .o_done(o_done), .o_invalid_opcode_fault(o_invalid_opcode_fault),
    .o_device_absent_fault(o_device_absent_fault), .o_packed_data(o_packed_data),
    .o_fp_data(o_fp_data), .o_saved_tags(o_saved_tags), .o_tag_word(o_tag_word),
    .o_status_word(o_status_word));
  function [15:0] nx(input [15:0] a);
    nx = {a[14:0], a[15] ^ a[13] ^ a[12] ^ a[10]};
  endfunction
  function [79:0] pk_img(input [63:0] a);
    pk_img = {16'hffff, a};
  endfunction
  task chk(input string w, input [79:0] sn, input [79:0] ex);
    begin
      total_checks = total_checks + 1;
      if (sn !== ex) begin
        n_fail = n_fail + 1;
        $display("MISMATCH %0s exp %h seen %h", w, ex, sn);
      end
    end
  endtask
  task results;
    begin
      $display("checks %0d failures %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
    end
  endtask
  task op(input [3:0] a, input [2:0] b, input [79:0] e, input [15:0] t);
    integer j;
    begin
      i_psfra_pipe_model.issue(a, b, e, t, s);
      #1;
      for (j = 0; j < 4 && !(o_done | o_invalid_opcode_fault | o_device_absent_fault); j++)
        @(posedge i_ref_clk) #1;
      if (j == 4) begin
        n_fail = n_fail + 1;
        results;
      end
      dn = o_done;
      ud = o_invalid_opcode_fault;
      nm = o_device_absent_fault;
      @(posedge i_ref_clk) #1;
    end
  endtask
  initial begin
    repeat (4) @(posedge i_ref_clk);
    i_srst <= 1'b0;
    for (k = 0; k < 4; k++) begin
      @(posedge i_ref_clk);
      i_emulation_flag <= k[1];
      i_task_switched_flag <= k[0];
      op(4'h2, 3'h5, 80'h0, 16'h0);
      chk("ud", ud, k[1]);
      chk("nm", nm, k == 1);
      chk("done", dn, k == 0);
    end
    @(posedge i_ref_clk);
    i_emulation_flag <= 1'b0;
    i_task_switched_flag <= 1'b0;
    for (k = 0; k < 4; k++) begin
      repeat (5) begin
        lf = nx(lf);
        d = {d[63:0], lf};
      end
      s = nx(lf);
      op(4'h2, lf[2:0], d, 16'h0);
      chk("tags", o_tag_word, 16'h0);
      op(4'h6, lf[2:0], d, 16'h0);
      chk("fp", o_fp_data, pk_img(d[63:0]));
      op(4'h4, lf[2:0], d, 16'h0);
      op(4'h1, lf[2:0], 80'h0, 16'h0);
      chk("pk", o_packed_data, d[63:0]);
      chk("sw", o_status_word, s & 16'hc7ff);
      op(4'h3, lf[2:0], 80'h0, 16'h0);
      chk("clr", o_tag_word, 16'hffff);
      op(4'h1, lf[2:0], 80'h0, 16'h0);
      chk("tagfree", o_packed_data, d[63:0]);
      op(4'h6, lf[2:0], 80'h0, 16'h0);
      chk("keep", o_fp_data, d);
    end
    op(4'h4, 3'h0, 80'h0, 16'h0);
    op(4'h4, 3'h1, {16'h3fff, 64'h8000000000000000}, 16'h0);
    op(4'h4, 3'h2, {16'h7fff, d[63:0]}, 16'h0);
    for (k = 3; k < 8; k++) op(4'h5, k[2:0], d, 16'h0);
    op(4'h7, 3'h0, d, 16'h0);
    chk("save", o_saved_tags, 16'hffe1);
    chk("empty", o_tag_word, 16'hffff);
    op(4'h8, 3'h0, d, 16'hffc3);
    chk("rest", o_tag_word, 16'hffe3);
    results;
  end
endmodule // psfra_regfile_bench
